// file: verification/far_side_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Supply side: regulation, error, output and inhibit pin
// ----------------------------------------
module far_side_model (
    input wire logic hclk,
    input wire logic set_err,
    input wire logic set_cc,
    input wire logic set_on,
    input wire logic set_inh,
    input wire logic relay_on,
    output logic sys_error,
    output logic cc_mode,
    output logic output_on,
    output logic output_inhibit_input,
    output logic contact_closed
);
    // Lines change one edge after the request, like a slow analog source
    always_ff @(posedge hclk) begin
        sys_error <= set_err;
        cc_mode <= set_cc;
        output_on <= set_on;
        output_inhibit_input <= set_inh;
    end
    // Contact follows the coil directly
    assign contact_closed = relay_on;
endmodule

// file: verification/tb_relay_ctl.sv
`timescale 1ns/1ps
`include "relay_ctl_cfg.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
module tb_relay_ctl
    import relay_ctl_pkg::*;
;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [11:0] haddr = 0;
    logic [1:0] htrans = 0;
    logic [31:0] hwdata = 0, hrdata, q;
    logic set_err = 0, set_cc = 0, set_on = 0, set_inh = 0, password_ok = 0;
    logic fast_power_up_saved = 0;
    logic sys_error, cc_mode, output_on, output_inhibit_input;
    logic relay_on, output_disable, fast_power_up, irq, contact_closed;
    int n_errors = 0, n_tests = 0, cyc = 0;
    always #10 hclk = ~hclk;
    relay_ctl #(.HALF_SEC_CYCLES(10)) u_relay_ctl (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .sys_error(sys_error), .cc_mode(cc_mode), .output_on(output_on),
        .output_inhibit_input(output_inhibit_input), .password_ok(password_ok),
        .fast_power_up_saved(fast_power_up_saved), .relay_on(relay_on),
        .output_disable(output_disable), .fast_power_up(fast_power_up), .irq(irq));
    far_side_model u_far_side_model (.hclk(hclk), .set_err(set_err), .set_cc(set_cc),
        .set_on(set_on), .set_inh(set_inh), .relay_on(relay_on), .sys_error(sys_error),
        .cc_mode(cc_mode), .output_on(output_on),
        .output_inhibit_input(output_inhibit_input), .contact_closed(contact_closed));
    // ----------------------------------------
    // Bus master and checks
    // ----------------------------------------
    task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
        ahb(1'b0, a, 32'h0000_0000);
        `CHK("register", e, q & m)
        `CHK("hresp", 1'b0, hresp)
    endtask
    // Bounded wait; the relay passes a two-flop sync plus a register
    task automatic wait_rel(input logic e, input int n);
        for (int i = 0; i < n && relay_on !== e; i++) @(posedge hclk);
        `CHK("relay_on", e, relay_on)
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Hang guard, well above the sequence length
    always @(posedge hclk) begin
        cyc++;
        if (cyc > 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        idle(3);
        hresetn <= 1'b1;
        rd(`OFF_CTRL, 32'h4f, 32'h40);
        rd(`OFF_DELAY, 32'h1ff, 32'h2);
        rd(`OFF_STAT, 32'h1, 32'h0);
        rd(`OFF_PASS, 32'hffff_ffff, 32'h0);
        rd(12'h100, 32'hffff_ffff, 32'h0);
        wr(`OFF_CTRL, 32'h43);
        rd(`OFF_CTRL, 32'h4f, 32'h40);
        // Error trip, status readback and interrupt masking
        wr(`OFF_IRQ_MASK, 32'h1);
        set_err <= 1'b1;
        wait_rel(1'b1, 8);
        rd(`OFF_STAT, 32'h1, 32'h1);
        `CHK("irq", 1'b1, irq)
        `CHK("contact_closed", 1'b1, contact_closed)
        set_err <= 1'b0;
        wait_rel(1'b0, 8);
        wr(`OFF_IRQ_STAT, 32'hf);
        idle(2);
        `CHK("irq", 1'b0, irq)
        // Delay limits: zero and 257 refused, 256 and 1 taken
        wr(`OFF_DELAY, 32'h0);
        rd(`OFF_DELAY, 32'h1ff, 32'h2);
        rd(`OFF_STAT, 32'h20, 32'h20);
        rd(`OFF_IRQ_STAT, 32'h4, 32'h4);
        wr(`OFF_DELAY, 32'h101);
        rd(`OFF_DELAY, 32'h1ff, 32'h2);
        wr(`OFF_DELAY, 32'h100);
        rd(`OFF_DELAY, 32'h1ff, 32'h100);
        wr(`OFF_DELAY, 32'h1);
        rd(`OFF_DELAY, 32'h1ff, 32'h1);
        wr(`OFF_DELAY, 32'h2);
        // Voltage to current trip, with an early leave restarting the timer
        wr(`OFF_CTRL, 32'h44);
        set_on <= 1'b1;
        set_cc <= 1'b1;
        idle(12);
        `CHK("relay_on", 1'b0, relay_on)
        set_cc <= 1'b0;
        idle(4);
        set_cc <= 1'b1;
        idle(12);
        `CHK("relay_on", 1'b0, relay_on)
        wait_rel(1'b1, 40);
        set_cc <= 1'b0;
        wait_rel(1'b0, 8);
        set_cc <= 1'b1;
        wait_rel(1'b1, 50);
        set_on <= 1'b0;
        wait_rel(1'b0, 8);
        // Current to voltage trip
        set_on <= 1'b1;
        wr(`OFF_CTRL, 32'h48);
        idle(40);
        `CHK("relay_on", 1'b0, relay_on)
        set_cc <= 1'b0;
        idle(10);
        `CHK("relay_on", 1'b0, relay_on)
        wait_rel(1'b1, 40);
        set_cc <= 1'b1;
        wait_rel(1'b0, 8);
        // Operator mode: only a confirmed choice moves the relay
        wr(`OFF_CTRL, 32'h71);
        wait_rel(1'b1, 4);
        wr(`OFF_CTRL, 32'h41);
        idle(4);
        `CHK("relay_on", 1'b1, relay_on)
        wr(`OFF_CTRL, 32'h61);
        wait_rel(1'b0, 4);
        // Sequence mode ignores errors and follows commands
        wr(`OFF_CTRL, 32'h42);
        set_err <= 1'b1;
        idle(8);
        `CHK("relay_on", 1'b0, relay_on)
        wr(`OFF_CMD, 32'h1);
        wait_rel(1'b1, 4);
        wr(`OFF_CMD, 32'h2);
        wait_rel(1'b0, 4);
        set_err <= 1'b0;
        wr(`OFF_CTRL, 32'h46);
        wr(`OFF_CMD, 32'h4);
        rd(`OFF_CTRL, 32'hf, 32'h0);
        // Inhibit polarity behind the password
        set_inh <= 1'b1;
        idle(6);
        `CHK("output_disable", 1'b1, output_disable)
        wr(`OFF_CTRL, 32'h00);
        rd(`OFF_IRQ_STAT, 32'h8, 32'h8);
        `CHK("output_disable", 1'b1, output_disable)
        password_ok <= 1'b1;
        wr(`OFF_CTRL, 32'h00);
        idle(6);
        `CHK("output_disable", 1'b0, output_disable)
        rd(`OFF_STAT, 32'h12, 32'h10);
        set_inh <= 1'b0;
        idle(6);
        `CHK("output_disable", 1'b1, output_disable)
        rd(`OFF_STAT, 32'h12, 32'h12);
        password_ok <= 1'b0;
        // Fast power-up: staged until confirmed
        wr(`OFF_BOOT, 32'h1);
        rd(`OFF_BOOT, 32'h3, 32'h3);
        `CHK("fast_power_up", 1'b0, fast_power_up)
        wr(`OFF_BOOT, 32'h3);
        rd(`OFF_BOOT, 32'h3, 32'h1);
        rd(`OFF_STAT, 32'hc, 32'h4);
        `CHK("fast_power_up", 1'b1, fast_power_up)
        // Second reset: operator state is not kept
        wr(`OFF_CTRL, 32'h71);
        wait_rel(1'b1, 4);
        hresetn <= 1'b0;
        idle(3);
        hresetn <= 1'b1;
        idle(2);
        `CHK("relay_on", 1'b0, relay_on)
        rd(`OFF_CTRL, 32'h4f, 32'h40);
        give_verdict();
    end
endmodule

// file: verilog/half_sec_tick.sv
`timescale 1ns/1ps
`include "relay_ctl_cfg.svh"

module half_sec_tick
    import relay_ctl_pkg::*;
#(
    parameter int unsigned CYCLES = `HALF_SEC_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic restart,
    output logic tick
);

    typedef struct packed {
        logic [31:0] cnt;
        logic tick;
    } tick_state_t;

    tick_state_t s_r;
    tick_state_t s_nxt;

    // Free divider, restarted so a new wait counts whole half seconds
    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (restart) begin
            s_nxt.cnt = 32'h0;
        end else if (s_r.cnt == CYCLES - 1) begin
            s_nxt.cnt = 32'h0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.cnt = s_r.cnt + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule

// file: verilog/relay_ctl.sv
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`include "relay_ctl_cfg.svh"
// Notes on behaviour
// - Three relay modes: fault, operator, sequence; fault mode after reset.
// - Error-only trigger: relay on at once for any system error.
// - Voltage-to-current trigger: relay on after delay in current regulation.
// - Current-to-voltage trigger: relay on after delay in voltage regulation.
// - Delay 0.5 to 128.0 s in half seconds; zero is rejected.
// - Transition trip only after the full delay in the new mode.
// - Delay resets to one second.
// - Transition trip drops on return to old mode or output off.
// - Operator mode drives the confirmed on/off state immediately.
// - Relay is off after every reset; manual state not kept.
// - Sequence mode: relay follows remote sequence commands only.
// - Wipe command returns to fault mode with error-only trigger.
// - Present relay state is readable in status.
// - Fast power-up flag tells boot to skip displays and enter setpoint.
// - Inhibit polarity selectable; active level disables the output.
// - Polarity change only while the password is accepted.
// - Fast power-up change stays pending until confirmed.

module relay_ctl
    import relay_ctl_pkg::*;
#(
    parameter int unsigned HALF_SEC_CYCLES = `HALF_SEC_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic sys_error,
    input wire logic cc_mode,
    input wire logic output_on,
    input wire logic output_inhibit_input,
    input wire logic password_ok,
    input wire logic fast_power_up_saved,
    output logic relay_on,
    output logic output_disable,
    output logic fast_power_up,
    output logic irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] cc_sync;
        logic [1:0] inh_sync;
        logic [1:0] err_sync;
        logic [1:0] on_sync;
        logic ph_wr;
        logic ph_rd;
        logic [11:0] ph_addr;
        logic [31:0] rdata;
        relay_mode_t mode;
        trig_sel_t trig;
        logic oper_on;
        logic seq_on;
        logic inh_pol;
        logic [`DELAY_W-1:0] delay;
        logic [`DELAY_W-1:0] elapsed;
        logic trans_trip;
        logic relay;
        logic inhibit;
        logic boot_latched;
        logic fast_cur;
        logic fast_pend_val;
        logic fast_pend;
        logic delay_bad;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        logic irq;
    } relay_state_t;

    relay_state_t s_r;
    relay_state_t s_nxt;
    logic tick;
    logic in_new;
    logic timer_hold;

    // True when a half-second count satisfies the accepted range
    function automatic logic delay_ok(input logic [31:0] v);
        delay_ok = (v >= 32'(`DELAY_MIN)) && (v <= 32'(`DELAY_MAX));
    endfunction

    // ------------------------------------------------------------
    // Half-second time base
    // ------------------------------------------------------------
    // Regulation sits in the mode that the chosen trigger watches
    assign in_new = (s_r.trig == TRIG_V2C) ? s_r.cc_sync[1] : !s_r.cc_sync[1];
    // Divider held with the timer, so the first tick lands a whole half second in
    assign timer_hold = (s_r.mode != MODE_FAULT) || (s_r.trig == TRIG_ERR) ||
        !s_r.on_sync[1] || !in_new;

    half_sec_tick #(
        .CYCLES(HALF_SEC_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .restart(timer_hold),
        .tick(tick)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic trip_now;
        logic [`IRQ_W-1:0] ev;
        logic [`IRQ_W-1:0] w1c;
        logic rd_hit;
        trip_now = 1'b0;
        ev = '0;
        w1c = '0;
        rd_hit = 1'b0;
        s_nxt = s_r;

        // Pins cross two flops before use
        s_nxt.cc_sync = {s_r.cc_sync[0], cc_mode};
        s_nxt.inh_sync = {s_r.inh_sync[0], output_inhibit_input};
        s_nxt.err_sync = {s_r.err_sync[0], sys_error};
        s_nxt.on_sync = {s_r.on_sync[0], output_on};

        // Fast power-up state captured once after reset release
        if (!s_r.boot_latched) begin
            s_nxt.boot_latched = 1'b1;
            s_nxt.fast_cur = fast_power_up_saved;
            s_nxt.fast_pend_val = fast_power_up_saved;
        end

        // Bus address phase capture
        s_nxt.ph_wr = hsel && hready && htrans[1] && hwrite;
        s_nxt.ph_rd = hsel && hready && htrans[1] && !hwrite;
        if (hsel && hready && htrans[1]) begin
            s_nxt.ph_addr = haddr;
        end

        // Write data phase
        if (s_r.ph_wr) begin
            unique case (s_r.ph_addr)
                `OFF_CTRL: begin
                    if (hwdata[`CTRL_MODE_LSB +: 2] != 2'b11) begin
                        s_nxt.mode = relay_mode_t'(hwdata[`CTRL_MODE_LSB +: 2]);
                    end
                    if (hwdata[`CTRL_TRIG_LSB +: 2] != 2'b11) begin
                        s_nxt.trig = trig_sel_t'(hwdata[`CTRL_TRIG_LSB +: 2]);
                    end
                    if (hwdata[`CTRL_CONFIRM]) begin
                        s_nxt.oper_on = hwdata[`CTRL_OPER_ON];
                    end
                    if (hwdata[`CTRL_INH_POL] != s_r.inh_pol) begin
                        if (password_ok) begin
                            s_nxt.inh_pol = hwdata[`CTRL_INH_POL];
                        end else begin
                            ev[`IRQ_POL_REJ] = 1'b1;
                        end
                    end
                end
                `OFF_DELAY: begin
                    if (delay_ok(hwdata)) begin
                        s_nxt.delay = hwdata[`DELAY_W-1:0];
                        s_nxt.delay_bad = 1'b0;
                    end else begin
                        s_nxt.delay_bad = 1'b1;
                        ev[`IRQ_DELAY_REJ] = 1'b1;
                    end
                end
                `OFF_CMD: begin
                    if (hwdata[`CMD_SEQ_ON]) begin
                        s_nxt.seq_on = 1'b1;
                    end else if (hwdata[`CMD_SEQ_OFF]) begin
                        s_nxt.seq_on = 1'b0;
                    end
                    if (hwdata[`CMD_WIPE]) begin
                        s_nxt.mode = MODE_FAULT;
                        s_nxt.trig = TRIG_ERR;
                    end
                end
                `OFF_BOOT: begin
                    // Bit 0 stages a value, bit 1 confirms it
                    s_nxt.fast_pend_val = hwdata[0];
                    s_nxt.fast_pend = (hwdata[0] != s_r.fast_cur) && !hwdata[1];
                    if (hwdata[1]) begin
                        s_nxt.fast_cur = hwdata[0];
                    end
                end
                `OFF_IRQ_STAT: w1c = hwdata[`IRQ_W-1:0];
                `OFF_IRQ_MASK: s_nxt.irq_mask = hwdata[`IRQ_W-1:0];
                default: ;
            endcase
        end

        // Transition trip timing, restarted whenever regulation leaves the new mode
        if (timer_hold) begin
            s_nxt.elapsed = '0;
            s_nxt.trans_trip = 1'b0;
        end else if (!s_r.trans_trip && tick) begin
            s_nxt.elapsed = s_r.elapsed + 1'b1;
            if (s_r.elapsed + 1'b1 >= s_r.delay) begin
                s_nxt.trans_trip = 1'b1;
            end
        end

        // Relay drive per mode
        unique case (s_r.mode)
            MODE_FAULT: trip_now = s_r.err_sync[1] || s_r.trans_trip;
            MODE_OPER: trip_now = s_r.oper_on;
            MODE_SEQ: trip_now = s_r.seq_on;
            default: trip_now = 1'b0;
        endcase
        s_nxt.relay = trip_now;
        ev[`IRQ_RELAY_ON] = trip_now && !s_r.relay;
        ev[`IRQ_RELAY_OFF] = !trip_now && s_r.relay;

        // Inhibit at chosen active level
        s_nxt.inhibit = (s_r.inh_sync[1] == s_r.inh_pol);

        // Sticky events; a new event beats a same-cycle clear
        s_nxt.irq_stat = (s_r.irq_stat & ~w1c) | ev;
        s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);

        // Read data phase
        rd_hit = hsel && hready && htrans[1] && !hwrite;
        if (rd_hit) begin
            s_nxt.rdata = '0;
            unique case (haddr)
                `OFF_CTRL: begin
                    s_nxt.rdata[`CTRL_MODE_LSB +: 2] = s_r.mode;
                    s_nxt.rdata[`CTRL_TRIG_LSB +: 2] = s_r.trig;
                    s_nxt.rdata[`CTRL_OPER_ON] = s_r.oper_on;
                    s_nxt.rdata[`CTRL_INH_POL] = s_r.inh_pol;
                end
                `OFF_DELAY: s_nxt.rdata[`DELAY_W-1:0] = s_r.delay;
                `OFF_STAT: begin
                    s_nxt.rdata[`STAT_RELAY] = s_r.relay;
                    s_nxt.rdata[`STAT_INHIBIT] = s_r.inhibit;
                    s_nxt.rdata[`STAT_FAST_ACTIVE] = s_r.fast_cur;
                    s_nxt.rdata[`STAT_FAST_PENDING] = s_r.fast_pend;
                    s_nxt.rdata[`STAT_UNLOCKED] = password_ok;
                    s_nxt.rdata[`STAT_DELAY_BAD] = s_r.delay_bad;
                end
                `OFF_IRQ_STAT: s_nxt.rdata[`IRQ_W-1:0] = s_r.irq_stat;
                `OFF_IRQ_MASK: s_nxt.rdata[`IRQ_W-1:0] = s_r.irq_mask;
                `OFF_BOOT: s_nxt.rdata[1:0] = {s_r.fast_pend, s_r.fast_pend_val};
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Reset brings up relay off and factory config
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.mode <= MODE_FAULT;
            s_r.trig <= TRIG_ERR;
            s_r.inh_pol <= 1'b1;
            s_r.delay <= `DELAY_DEF;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hrdata = s_r.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign relay_on = s_r.relay;
    assign output_disable = s_r.inhibit;
    assign fast_power_up = s_r.fast_cur;
    assign irq = s_r.irq;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    relay_reset_a: assert property (@(posedge hclk) $rose(hresetn) |-> !relay_on)
        else $error("relay on after reset");

    err_trip_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.mode == MODE_FAULT && s_r.err_sync[1]) |=> relay_on)
        else $error("error did not trip relay");

    oper_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.mode == MODE_OPER) |=> (relay_on == $past(s_r.oper_on)))
        else $error("operator state not driven");

    seq_drive_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.mode == MODE_SEQ) |=> (relay_on == $past(s_r.seq_on)))
        else $error("sequence state not driven");

    delay_range_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.delay >= `DELAY_MIN) && (s_r.delay <= `DELAY_MAX))
        else $error("delay out of range");

    trip_wait_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(s_r.trans_trip) |-> ($past(s_r.elapsed) + 1'b1 >= s_r.delay))
        else $error("trip before full delay");

    trip_drop_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.trans_trip && !s_r.on_sync[1]) |=> !s_r.trans_trip)
        else $error("trip held with output off");

    inh_follow_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ##1 (output_disable == ($past(s_r.inh_sync[1]) == $past(s_r.inh_pol))))
        else $error("inhibit level wrong");

    pol_lock_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.inh_pol != $past(s_r.inh_pol)) |-> $past(password_ok))
        else $error("polarity changed while locked");

    wipe_cfg_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.ph_wr && s_r.ph_addr == `OFF_CMD && hwdata[`CMD_WIPE])
        |=> (s_r.mode == MODE_FAULT && s_r.trig == TRIG_ERR))
        else $error("wipe did not restore defaults");

    hold_clear_a: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_hold |=> (s_r.elapsed == '0 && !s_r.trans_trip))
        else $error("timer not cleared outside new mode");

    hold_tick_a: assert property (@(posedge hclk) disable iff (!hresetn)
        timer_hold |=> !tick)
        else $error("half-second tick during hold");

    delay_rej_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.ph_wr && s_r.ph_addr == `OFF_DELAY && !delay_ok(hwdata))
        |=> (s_r.delay == $past(s_r.delay) && s_r.irq_stat[`IRQ_DELAY_REJ]))
        else $error("bad delay not refused");

    boot_confirm_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (s_r.ph_wr && s_r.ph_addr == `OFF_BOOT && hwdata[1])
        |=> (!s_r.fast_pend && fast_power_up == $past(hwdata[0])))
        else $error("confirm did not apply setting");

    relay_event_a: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(relay_on) |-> s_r.irq_stat[`IRQ_RELAY_ON])
        else $error("relay rise not recorded");

endmodule

// file: verilog/relay_ctl_cfg.svh
`ifndef RELAY_CTL_CFG_SVH
`define RELAY_CTL_CFG_SVH

// Register byte offsets
`define OFF_CTRL 12'h000
`define OFF_DELAY 12'h004
`define OFF_STAT 12'h008
`define OFF_IRQ_STAT 12'h00c
`define OFF_IRQ_MASK 12'h010
`define OFF_CMD 12'h014
`define OFF_PASS 12'h018
`define OFF_BOOT 12'h01c

// Control register fields
`define CTRL_MODE_LSB 0
`define CTRL_TRIG_LSB 2
`define CTRL_OPER_ON 4
`define CTRL_CONFIRM 5
`define CTRL_INH_POL 6

// Command register fields (write-only pulses)
`define CMD_SEQ_ON 0
`define CMD_SEQ_OFF 1
`define CMD_WIPE 2

// Status register fields
`define STAT_RELAY 0
`define STAT_INHIBIT 1
`define STAT_FAST_ACTIVE 2
`define STAT_FAST_PENDING 3
`define STAT_UNLOCKED 4
`define STAT_DELAY_BAD 5

// Interrupt status bits
`define IRQ_RELAY_ON 0
`define IRQ_RELAY_OFF 1
`define IRQ_DELAY_REJ 2
`define IRQ_POL_REJ 3
`define IRQ_W 4

// Delay in half seconds: 0.5 s to 128.0 s, default 1.0 s
`define DELAY_W 9
`define DELAY_MIN 9'd1
`define DELAY_MAX 9'd256
`define DELAY_DEF 9'd2

// Half-second tick from the 50 MHz clock
`define HALF_SEC_MS 500
`define CLK_MHZ 50
`define HALF_SEC_CYC (`HALF_SEC_MS * 1000 * `CLK_MHZ)

`endif

// file: verilog/relay_ctl_pkg.sv
package relay_ctl_pkg;

typedef enum logic [1:0] {
    MODE_FAULT = 2'b00,
    MODE_OPER = 2'b01,
    MODE_SEQ = 2'b10
} relay_mode_t;

typedef enum logic [1:0] {
    TRIG_ERR = 2'b00,
    TRIG_V2C = 2'b01,
    TRIG_C2V = 2'b10
} trig_sel_t;

endpackage
